// ### srxu_cfg.svh
// Constants of the serial port receiver and transmitter.
`ifndef SRXU_CFG_SVH
`define SRXU_CFG_SVH
`define SRXU_CLK_HZ      100000000
`define SRXU_TICK_NS     10000
`define SRXU_TICK_CYC    (`SRXU_TICK_NS / 10)
`define SRXU_A_CFG       4'h0
`define SRXU_A_TXDATA    4'h1
`define SRXU_A_RXDATA    4'h2
`define SRXU_A_STATUS    4'h3
`define SRXU_A_IDLE      4'h4
`define SRXU_A_STAMP     4'h5
`define SRXU_CFG_RST     16'h903B
`endif

// ### srxu_pkg.sv
// Types of the serial port receiver and transmitter.
package srxu_pkg;
   typedef enum logic [2:0] {SRXU_PAR_NONE, SRXU_PAR_ODD, SRXU_PAR_EVEN,
                             SRXU_PAR_MARK, SRXU_PAR_SPACE} srxu_par_e;
   typedef enum logic [1:0] {SRXU_ST_IDLE, SRXU_ST_START, SRXU_ST_BITS,
                             SRXU_ST_STOP} srxu_state_e;
   typedef struct packed {
      logic [15:0] stamp;
      logic [7:0]  err;
      logic [7:0]  data;
   } srxu_rec_s;
   // Divisor per sixteenth of a bit at 100 MHz for each rate code.
   function automatic logic [15:0] srxu_div(input logic [3:0] code);
      logic [15:0] d;
      d = 16'h0036;
      unique case (code)
         4'h0: d = 16'h7A12;
         4'h1: d = 16'h516C;
         4'h2: d = 16'h28B6;
         4'h3: d = 16'h145B;
         4'h4: d = 16'h0D90;
         4'h5: d = 16'h0A2C;
         4'h6: d = 16'h0516;
         4'h7: d = 16'h028B;
         4'h8: d = 16'h0145;
         4'h9: d = 16'h00A3;
         4'hA: d = 16'h006C;
         default: d = 16'h0036;
      endcase
      return d;
   endfunction : srxu_div
endpackage : srxu_pkg

// ### srxu_if.sv
// Interface between the receive core and the top of the serial port.
`timescale 1ns/100ps
interface srxu_if;
   import srxu_pkg::*;
   logic      os16;
   logic [1:0] len;
   logic [2:0] par;
   logic       stop2;
   logic       push;
   srxu_rec_s  rec;
   logic       rx_end;
   modport core (input os16, len, par, stop2, output push, rec, rx_end);
   modport top  (output os16, len, par, stop2, input push, rec, rx_end);
endinterface : srxu_if

// ### srxu_rx.sv
// Receive core: frames one character and flags its errors.
`timescale 1ns/100ps
module srxu_rx
   import srxu_pkg::*;
(
   input  wire logic clk,
   input  wire logic rstn,
   input  wire logic rx_s,
   srxu_if.core      bus
);
   srxu_state_e st_q;
   logic [3:0]  ph_q;
   logic [3:0]  bit_q;
   logic [7:0]  sh_q;
   logic        pbit_q;
   logic        zero_q;
   logic        rx_d_q;
   logic        push_q;
   logic [7:0]  data_q;
   logic [7:0]  err_q;
   wire [3:0] nbits   = 4'h5 + {2'b00, bus.len};
   wire       haspar  = bus.par != SRXU_PAR_NONE;
   wire [3:0] total   = nbits + {3'b000, haspar};
   wire       mid     = bus.os16 && ph_q == 4'h7;
   wire [7:0] msk     = 8'hFF >> (4'h8 - nbits);
   wire [7:0] dat     = (sh_q >> (4'h8 - nbits)) & msk;
   wire       xr      = ^dat;
   wire       exp_p   = (bus.par == SRXU_PAR_ODD)  ? ~xr :
                        (bus.par == SRXU_PAR_EVEN) ? xr  :
                        (bus.par == SRXU_PAR_MARK);
   wire       perr    = haspar && (pbit_q != exp_p);
   wire       ferr    = !rx_s;
   wire       brk     = ferr && zero_q;
   wire [7:0] err_n   = {1'b0, 1'b0, perr, ferr, brk, 2'b00, (perr | ferr)};
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st_q <= SRXU_ST_IDLE;
         ph_q <= 4'h0;
         bit_q <= 4'h0;
         sh_q <= 8'h00;
         pbit_q <= 1'b0;
         zero_q <= 1'b0;
         push_q <= 1'b0;
         rx_d_q <= 1'b1;
         data_q <= 8'h00;
         err_q <= 8'h00;
      end else begin
         push_q <= 1'b0;
         rx_d_q <= rx_s;
         if (bus.os16) ph_q <= (st_q == SRXU_ST_IDLE) ? 4'h0 : ph_q + 4'h1;
         unique case (st_q)
            // A start needs a falling edge, so a line held low after a break
            // yields one character rather than a stream of them.
            SRXU_ST_IDLE: if (rx_d_q && !rx_s) st_q <= SRXU_ST_START;
            SRXU_ST_START: if (mid) begin
               st_q <= rx_s ? SRXU_ST_IDLE : SRXU_ST_BITS;
               bit_q <= 4'h0;
               zero_q <= 1'b1;
            end
            SRXU_ST_BITS: if (mid) begin
               if (rx_s) zero_q <= 1'b0;
               if (bit_q < nbits) sh_q <= {rx_s, sh_q[7:1]};
               else pbit_q <= rx_s;
               bit_q <= bit_q + 4'h1;
               if (bit_q + 4'h1 == total) st_q <= SRXU_ST_STOP;
            end
            SRXU_ST_STOP: if (mid) begin
               st_q <= SRXU_ST_IDLE;
               push_q <= 1'b1;
               data_q <= dat;
               err_q <= err_n;
            end
         endcase
      end
   end
   // The stop half is not waited for in full, so back-to-back characters keep step.
   assign bus.push = push_q;
   assign bus.rec  = '{stamp: 16'h0000, err: err_q, data: data_q};
   assign bus.rx_end = push_q;
   stop_len_a: assert property (@(posedge clk) disable iff (!rstn)
      push_q |-> $past(st_q) == SRXU_ST_STOP) else $error("push without stop");
   brk_err_a: assert property (@(posedge clk) disable iff (!rstn)
      push_q && err_q[3] |-> err_q[4] && err_q[0]) else $error("break flags");
   err_zero_a: assert property (@(posedge clk) disable iff (!rstn)
      err_q[2:1] == 2'b00) else $error("unused error bits set");
   rx_push_c: cover property (@(posedge clk) disable iff (!rstn) push_q && !err_q[0]);
endmodule : srxu_rx

// ### srxu_top.sv
// Serial port with register port, receive FIFO, idle stamp and transmitter.
`timescale 1ns/100ps
`include "srxu_cfg.svh"
module srxu_top
   import srxu_pkg::*;
#(
   parameter int DEPTH = 16
)(
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic [3:0]  addr,
   input  wire logic [15:0] wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic      [15:0] rdata,
   input  wire logic        rx_pin,
   output logic             tx_pin,
   output logic             tx_oe,
   output logic             rx_irq
);
   localparam int AW = $clog2(DEPTH);
   srxu_if bus();
   logic [15:0] cfg_q;
   logic        rs1_q, rs2_q;
   logic [15:0] div_q;
   logic        os16_q;
   logic [9:0]  tk_q;
   logic [15:0] idle_q;
   logic [31:0] mem [DEPTH];
   logic [AW-1:0] wp_q, rp_q;
   logic [AW:0]   cnt_q;
   logic          ovr_q;
   logic          lbo_q;
   logic [15:0]   rdata_q;
   logic [31:0]   rec_hold_q;
   // Config fields: [3:0] rate, [5:4] length-5, [8:6] parity, [9] two stop
   // bits, [10] extended, [12:11] threshold, [15] RS-485.
   wire [3:0] rate    = cfg_q[3:0];
   wire [2:0] par     = cfg_q[8:6];
   wire [1:0] len     = cfg_q[5:4];
   wire       stop_x  = cfg_q[9];
   wire       ext     = cfg_q[10];
   wire       rs485   = cfg_q[15];
   wire [4:0] thr     = (cfg_q[12:11] == 2'd0) ? 5'd1 : (cfg_q[12:11] == 2'd1) ? 5'd4 :
                        (cfg_q[12:11] == 2'd2) ? 5'd8 : 5'd14;
   wire       wr_cfg  = wr && addr == `SRXU_A_CFG;
   wire       wr_tx   = wr && addr == `SRXU_A_TXDATA;
   wire       rd_rx   = rd && addr == `SRXU_A_RXDATA;
   wire       empty   = cnt_q == '0;
   wire       full    = cnt_q == (AW+1)'(DEPTH);
   wire       pop     = rd_rx && !empty;
   wire       push    = bus.push;
   logic      tx_busy;
   logic      tx_done;
   assign bus.os16  = os16_q;
   assign bus.len   = len;
   assign bus.par   = par;
   assign bus.stop2 = stop_x;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rs1_q <= 1'b1;
         rs2_q <= 1'b1;
      end else begin
         rs1_q <= rx_pin;
         rs2_q <= rs1_q;
      end
   end
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) cfg_q <= `SRXU_CFG_RST;
      else if (wr_cfg) cfg_q <= wdata;
   end
   // A configuration write reloads the divider with the new rate at once.
   wire [3:0] rate_n  = wr_cfg ? wdata[3:0] : rate;
   // Sixteen-times bit clock enable.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         div_q <= 16'h0000;
         os16_q <= 1'b0;
      end else begin
         os16_q <= div_q == 16'h0000;
         div_q <= (div_q == 16'h0000 || wr_cfg) ? srxu_div(rate_n) - 16'h0001 : div_q - 16'h0001;
      end
   end
   // The 10 us tick restarts with the idle count, so no unit is gained from a
   // period that had partly run before the restart.
   wire       restart = bus.rx_end || wr_cfg || tx_done;
   wire       tick    = tk_q == 10'(`SRXU_TICK_CYC - 1);
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) tk_q <= 10'h000;
      else tk_q <= (tick || restart) ? 10'h000 : tk_q + 10'h001;
   end
   // Stamp taken at push is the silence before the character ends; it is
   // measured end to end, so it includes the character itself, a known limitation.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) idle_q <= 16'h0000;
      else if (restart) idle_q <= 16'h0000;
      else if (tick && idle_q != 16'hFFFF) idle_q <= idle_q + 16'h0001;
   end
   srxu_rx u_rx (
      .clk  (clk),
      .rstn (rstn),
      .rx_s (rs2_q),
      .bus  (bus)
   );
   wire [31:0] rec_in = {idle_q, bus.rec.err | {full, 6'h00, full}, bus.rec.data};
   always_ff @(posedge clk) begin
      if (push) mem[wp_q] <= rec_in;
   end
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) wp_q <= wp_q + 1'b1;
         if (pop || (push && full)) rp_q <= rp_q + 1'b1;
         if (push && !full && !pop) cnt_q <= cnt_q + 1'b1;
         else if (pop && !push) cnt_q <= cnt_q - 1'b1;
      end
   end
   // Overwrite on full keeps the newest data; the lost slot is flagged both ways.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) ovr_q <= 1'b0;
      else if (push && full) ovr_q <= 1'b1;
      else if (pop) ovr_q <= 1'b0;
   end
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) lbo_q <= 1'b0;
      else lbo_q <= push && full;
   end
   // A read takes the data word, with the error byte above it in extended mode; the same
   // pop latches the stamp into the hold register read at STAMP.
   wire [31:0] head    = mem[rp_q];
   wire [7:0]  err_out = head[15:8] | {1'b0, ovr_q, 5'h00, ovr_q};
   wire [15:0] rx_word = ext ? {err_out, head[7:0]} : {8'h00, head[7:0]};
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) rec_hold_q <= 32'h0000_0000;
      else if (pop) rec_hold_q <= {head[31:16], err_out, head[7:0]};
   end
   wire [15:0] status  = {8'h00, lbo_q, tx_busy, ovr_q, 5'(cnt_q)};
   wire [15:0] rd_mux  = (addr == `SRXU_A_CFG)    ? cfg_q :
                         (addr == `SRXU_A_RXDATA) ? (empty ? 16'h0000 : rx_word) :
                         (addr == `SRXU_A_STATUS) ? status :
                         (addr == `SRXU_A_IDLE)   ? idle_q :
                         (addr == `SRXU_A_STAMP)  ? rec_hold_q[31:16] : 16'h0000;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) rdata_q <= 16'h0000;
      else rdata_q <= rd ? rd_mux : 16'h0000;
   end
   assign rdata = rdata_q;
   assign rx_irq = cnt_q >= thr;
   srxu_tx u_tx (
      .clk   (clk),
      .rstn  (rstn),
      .os16  (os16_q),
      .len   (len),
      .par   (par),
      .stop_x(stop_x),
      .start (wr_tx),
      .data  (wdata[7:0]),
      .busy  (tx_busy),
      .done  (tx_done),
      .txd   (tx_pin)
   );
   // In two-wire mode the driver is enabled only while sending.
   assign tx_oe = rs485 ? tx_busy : 1'b1;
   irq_thr_a: assert property (@(posedge clk) disable iff (!rstn)
      cnt_q == 5'(thr) |-> rx_irq) else $error("irq missing at threshold");
   idle_sat_a: assert property (@(posedge clk) disable iff (!rstn)
      $past(idle_q) == 16'hFFFF && !$past(restart) |-> idle_q == 16'hFFFF)
      else $error("idle stamp wrapped");
   idle_rst_a: assert property (@(posedge clk) disable iff (!rstn)
      wr_cfg |=> idle_q == 16'h0000) else $error("idle not restarted");
   ovr_flag_a: assert property (@(posedge clk) disable iff (!rstn)
      push && full |=> ovr_q) else $error("overrun not flagged");
   oe_mode_a: assert property (@(posedge clk) disable iff (!rstn)
      !rs485 |-> tx_oe) else $error("four-wire driver off");
   fifo_c: cover property (@(posedge clk) disable iff (!rstn) full);
   ext_c: cover property (@(posedge clk) disable iff (!rstn) pop && ext);
   tx_c: cover property (@(posedge clk) disable iff (!rstn) tx_done);
endmodule : srxu_top

// ### srxu_tx.sv
// Transmitter framing one character with the receiver's settings.
`timescale 1ns/100ps
module srxu_tx
   import srxu_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rstn,
   input  wire logic       os16,
   input  wire logic [1:0] len,
   input  wire logic [2:0] par,
   input  wire logic       stop_x,
   input  wire logic       start,
   input  wire logic [7:0] data,
   output logic            busy,
   output logic            done,
   output logic            txd
);
   logic [11:0] sh_q;
   logic [4:0]  half_q;
   logic [3:0]  ph_q;
   logic        busy_q, done_q;
   wire [3:0] nb  = 4'h5 + {2'b00, len};
   wire [7:0] dm  = data & (8'hFF >> (4'h8 - nb));
   wire       hp  = par != SRXU_PAR_NONE;
   wire       pb  = (par == SRXU_PAR_ODD) ? ~^dm : (par == SRXU_PAR_EVEN) ? ^dm :
                    (par == SRXU_PAR_MARK);
   // Frame counted in half bits: stop 1, or 1.5 with five bits, else 2.
   wire [4:0] stp = !stop_x ? 5'd2 : (len == 2'd0) ? 5'd3 : 5'd4;
   wire [4:0] hl  = 5'd2 + {nb, 1'b0} + (hp ? 5'd2 : 5'd0) + stp;
   wire [11:0] word = (12'hFFF << (nb + {3'b000, hp})) | (hp ? (12'(pb) << nb) : 12'h000) | 12'(dm);
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sh_q <= 12'hFFF;
         half_q <= 5'd0;
         ph_q <= 4'h0;
         busy_q <= 1'b0;
         done_q <= 1'b0;
         txd <= 1'b1;
      end else begin
         done_q <= 1'b0;
         if (start && !busy_q) begin
            busy_q <= 1'b1;
            sh_q <= word;
            half_q <= hl;
            ph_q <= 4'h0;
            txd <= 1'b0;
         end else if (busy_q && os16) begin
            ph_q <= ph_q + 4'h1;
            if (ph_q[2:0] == 3'h7) begin
               half_q <= half_q - 5'd1;
               if (half_q == 5'd1) begin
                  busy_q <= 1'b0;
                  done_q <= 1'b1;
                  txd <= 1'b1;
               end else if (ph_q[3] && half_q > 5'd1) begin
                  txd <= sh_q[0];
                  sh_q <= {1'b1, sh_q[11:1]};
               end
            end
         end
      end
   end
   assign busy = busy_q;
   assign done = done_q;
   tx_idle_a: assert property (@(posedge clk) disable iff (!rstn)
      !busy_q |-> txd) else $error("line not idle");
   done_idle_a: assert property (@(posedge clk) disable iff (!rstn)
      done_q |-> !busy_q) else $error("done while busy");
endmodule : srxu_tx

// ### srxu_station.sv
// Remote serial station model that drives the receive line and captures the transmit line.
`timescale 1ns/100ps
module srxu_station #(
   parameter int BIT_CYC = 864
)(
   input  wire logic clk,
   input  wire logic txd,
   output logic      rxd
);
   // The line is biased to the idle mark level whenever no frame or break is sent.
   initial begin
      rxd = 1'b1;
   end

   // Frames are followed by one idle bit, far under the inter-byte limit.
   task automatic put(input logic [15:0] f, input int n);
      for (int i = 0; i < n; i++) begin
         rxd <= f[i];
         repeat (BIT_CYC) @(posedge clk);
      end
      rxd <= 1'b1;
      repeat (BIT_CYC) @(posedge clk);
   endtask : put

   task automatic hold_low(input int n);
      rxd <= 1'b0;
      repeat (n * BIT_CYC) @(posedge clk);
      rxd <= 1'b1;
      repeat (BIT_CYC) @(posedge clk);
   endtask : hold_low

   // Samples each bit in its middle, starting with the start bit.
   task automatic get(input int n, output logic [15:0] f);
      f = 16'h0000;
      @(negedge txd);
      repeat (BIT_CYC / 2) @(posedge clk);
      for (int i = 0; i < n; i++) begin
         f[i] = txd;
         if (i < n - 1) repeat (BIT_CYC) @(posedge clk);
      end
   endtask : get
endmodule : srxu_station

// ### tb_top.sv
// Self-checking testbench of the serial port.
`timescale 1ns/100ps
`include "srxu_cfg.svh"
module tb_top
   import srxu_pkg::*;
;
   localparam int BIT = 864;
   logic        clk;
   logic        rstn;
   logic [3:0]  addr;
   logic [15:0] wdata;
   logic        wr;
   logic        rd;
   logic [15:0] rdata;
   wire         rx_pin;
   logic        tx_pin;
   logic        tx_oe;
   logic        rx_irq;
   int          n_errors;
   int          tests_run;

   // A small FIFO keeps the overrun scenario short in simulated time.
   srxu_top #(.DEPTH(2)) u_dut (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .rx_pin(rx_pin), .tx_pin(tx_pin), .tx_oe(tx_oe),
      .rx_irq(rx_irq));
   srxu_station #(.BIT_CYC(BIT)) u_st (.clk(clk), .txd(tx_pin), .rxd(rx_pin));

   always #5 clk = ~clk;

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
   endtask : wr_reg

   task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
      #1 d = rdata;
   endtask : rd_reg

   function automatic logic [15:0] cfg(input logic [1:0] l, input logic [2:0] p,
                                       input logic s, input logic e, input logic [1:0] t);
      return {1'b1, 2'b00, t, e, s, p, l, 4'hB};
   endfunction : cfg

   function automatic int mk(input logic [7:0] d, input int n, input srxu_par_e pm,
                             input logic bad, input logic s0, output logic [15:0] f);
      logic p;
      int   k;
      f = 16'hFFFF;
      f[0] = 1'b0;
      for (int i = 0; i < n; i++) f[i+1] = d[i];
      k = n + 1;
      p = ^(d & (8'hFF >> (8 - n)));
      case (pm)
         SRXU_PAR_ODD:   p = ~p;
         SRXU_PAR_MARK:  p = 1'b1;
         SRXU_PAR_SPACE: p = 1'b0;
         default:        p = p;
      endcase
      if (pm != SRXU_PAR_NONE) begin
         f[k] = p ^ bad;
         k++;
      end
      f[k] = ~s0;
      return k + 1;
   endfunction : mk

   task automatic send(input logic [7:0] d, input int n, input srxu_par_e pm,
                       input logic bad, input logic s0);
      logic [15:0] f;
      int          nb;
      nb = mk(d, n, pm, bad, s0, f);
      u_st.put(f, nb);
   endtask : send

   task automatic t_reset;
      logic [15:0] v;
      rd_reg(`SRXU_A_CFG, v);
      check(v, 16'h903B);
      check({13'h0000, tx_oe, tx_pin, rx_irq}, 16'h0002);
      rd_reg(4'hF, v);
      check(v, 16'h0000);
      $display("test reset done");
   endtask : t_reset

   task automatic t_normal;
      logic [15:0] v;
      send(8'hA5, 8, SRXU_PAR_NONE, 1'b0, 1'b0);
      repeat (3000) @(posedge clk);
      rd_reg(`SRXU_A_IDLE, v);
      check({15'h0000, v >= 16'h0002 && v <= 16'h0005}, 16'h0001);
      rd_reg(`SRXU_A_STATUS, v);
      check(v & 16'h001F, 16'h0001);
      check({15'h0000, rx_irq}, 16'h0000);
      rd_reg(`SRXU_A_RXDATA, v);
      check(v, 16'h00A5);
      $display("test normal done");
   endtask : t_normal

   task automatic t_parity;
      srxu_par_e   pm [3] = '{SRXU_PAR_ODD, SRXU_PAR_MARK, SRXU_PAR_SPACE};
      logic [7:0]  er [3] = '{8'h00, 8'h21, 8'h11};
      logic [15:0] v;
      for (int i = 0; i < 3; i++) begin
         wr_reg(`SRXU_A_CFG, cfg(2'h0, pm[i], 1'b0, 1'b1, 2'h0));
         rd_reg(`SRXU_A_IDLE, v);
         check(v, 16'h0000);
         send(8'h16, 5, pm[i], i == 1, i == 2);
         check({15'h0000, rx_irq}, 16'h0001);
         rd_reg(`SRXU_A_RXDATA, v);
         check(v, {er[i], 8'h16});
         rd_reg(`SRXU_A_STAMP, v);
         check({15'h0000, v >= 16'h0005 && v <= 16'h0008}, 16'h0001);
      end
      $display("test parity done");
   endtask : t_parity

   task automatic t_overrun;
      logic [15:0] v;
      wr_reg(`SRXU_A_CFG, cfg(2'h0, SRXU_PAR_EVEN, 1'b0, 1'b1, 2'h1));
      send(8'h01, 5, SRXU_PAR_EVEN, 1'b0, 1'b0);
      send(8'h02, 5, SRXU_PAR_EVEN, 1'b1, 1'b0);
      send(8'h03, 5, SRXU_PAR_EVEN, 1'b0, 1'b0);
      rd_reg(`SRXU_A_STATUS, v);
      check(v & 16'h00FF, 16'h0022);
      check({15'h0000, rx_irq}, 16'h0000);
      rd_reg(`SRXU_A_RXDATA, v);
      check(v & 16'hFEFF, 16'h6002);
      rd_reg(`SRXU_A_RXDATA, v);
      check(v & 16'hFEFF, 16'h8003);
      u_st.hold_low(11);
      rd_reg(`SRXU_A_RXDATA, v);
      check(v, 16'h1900);
      $display("test overrun done");
   endtask : t_overrun

   task automatic t_tx;
      logic [15:0] f;
      logic [15:0] v;
      wr_reg(`SRXU_A_CFG, cfg(2'h3, SRXU_PAR_ODD, 1'b1, 1'b0, 2'h2));
      fork
         wr_reg(`SRXU_A_TXDATA, 16'h003C);
         u_st.get(12, f);
         begin
            repeat (3000) @(posedge clk);
            check({15'h0000, tx_oe}, 16'h0001);
         end
      join
      // Still driving in the middle of the second stop bit proves two stops.
      check({15'h0000, tx_oe}, 16'h0001);
      check(f & 16'h0FFF, 16'h0E78);
      repeat (1000) @(posedge clk);
      rd_reg(`SRXU_A_IDLE, v);
      check({15'h0000, v < 16'h0002}, 16'h0001);
      rd_reg(`SRXU_A_STATUS, v);
      check(v & 16'h00FF, 16'h0000);
      check({15'h0000, tx_oe}, 16'h0000);
      wr_reg(`SRXU_A_CFG, cfg(2'h3, SRXU_PAR_NONE, 1'b0, 1'b0, 2'h2) & 16'h7FFF);
      @(posedge clk);
      #1 check({15'h0000, tx_oe}, 16'h0001);
      $display("test transmit done");
   endtask : t_tx

   task automatic close_out;
      $display("checks %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : close_out

   initial begin
      // The scenarios need about 81,000 cycles; this leaves a margin.
      repeat (95000) @(posedge clk);
      n_errors++;
      $display("watchdog expired");
      close_out;
   end

   initial begin
      clk       = 1'b0;
      rstn      = 1'b0;
      addr      = 4'h0;
      wdata     = 16'h0000;
      wr        = 1'b0;
      rd        = 1'b0;
      n_errors  = 0;
      tests_run = 0;
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      t_reset;
      t_normal;
      t_parity;
      t_overrun;
      t_tx;
      close_out;
   end
endmodule : tb_top
